// ---- logic/ivmr_top.sv ----
// interrupt source mapping, priority-level selection with natural-order tie-break and reset entry sequencing
module ivmr_top
    import ivmr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ext_rst,
    input wire ivmr_src_s src,
    input wire logic [IVMR_NUM_IRQ-1:0] irq_enable,
    input wire logic [IVMR_NUM_IRQ*3-1:0] irq_priority,
    input wire ivmr_err_s err,
    input wire logic [23:0] fetch_word,
    output logic irq_valid,
    output logic [5:0] irq_num,
    output logic [5:0] vec_num,
    output logic [2:0] irq_level,
    output logic [IVMR_NUM_IRQ-1:0] irq_raw,
    output logic core_reset,
    output logic [5:0] reset_cause,
    output logic [23:0] fetch_addr,
    output logic fetch_req,
    output logic core_run
);
    ivmr_state_s st_r;
    ivmr_state_s st_nxt;
    logic [IVMR_NUM_IRQ-1:0] req;
    logic [5:0] best_num;
    logic [2:0] best_lvl;
    logic best_hit;
    logic err_reset;
    logic [5:0] err_vec;

    always_comb begin
        req = '0;
        req[IVMR_IRQ_EXT0] = src.ext_irq_zero;
        req[IVMR_IRQ_EXT1] = src.ext_irq_one;
        req[IVMR_IRQ_EXT2] = src.ext_irq_two;
        req[IVMR_IRQ_EXT3] = src.ext_irq_three;
        req[IVMR_IRQ_CAP1] = src.capture_ch_one;
        req[IVMR_IRQ_CMP1] = src.compare_ch_one;
        req[IVMR_IRQ_TMR1] = src.timer_one;
        req[IVMR_IRQ_CAP2] = src.capture_ch_two;
        req[IVMR_IRQ_CMP2] = src.compare_ch_two;
        req[IVMR_IRQ_TMR2] = src.timer_two;
        req[IVMR_IRQ_TMR3] = src.timer_three;
        req[IVMR_IRQ_SPI] = src.spi_event;
        req[IVMR_IRQ_ARX] = src.async_rx_event;
        req[IVMR_IRQ_ATX] = src.async_tx_event;
        req[IVMR_IRQ_ADC] = src.adc_done_event;
        req[IVMR_IRQ_NVW] = src.nonvolatile_write_done;
        req[IVMR_IRQ_TWT] = src.two_wire_target_event;
        req[IVMR_IRQ_TWC] = src.two_wire_controller_event;
        req[IVMR_IRQ_PCHG] = src.pin_change_event;
        req[IVMR_IRQ_CAP7] = src.capture_ch_seven;
        req[IVMR_IRQ_CAP8] = src.capture_ch_eight;
        req[IVMR_IRQ_PWMP] = src.pwm_period_match;
        req[IVMR_IRQ_QENC] = src.quadrature_encoder_event;
        req[IVMR_IRQ_PWM_FAULT_INPUT_A] = src.pwm_fault_input_a;
    end

    // natural order tie-break
    // scan from high number down; greater-or-equal hands a tie to the lower number
    always_comb begin
        logic [2:0] lvl;
        lvl = 3'h0;
        best_num = 6'h00;
        best_lvl = 3'h0;
        best_hit = 1'b0;
        for (int i = IVMR_NUM_IRQ - 1; i >= 0; i--) begin
            lvl = irq_priority[i*3 +: 3];
            // level zero disables a source
            if (req[i] && irq_enable[i] && lvl != 3'h0 && (!best_hit || lvl >= best_lvl)) begin
                best_hit = 1'b1;
                best_lvl = lvl;
                best_num = 6'(i);
            end
        end
    end

    always_comb begin
        err_vec = 6'h00;
        err_vec[5] = err.watchdog_expired;
        err_vec[4] = err.uninit_w_pointer;
        err_vec[3] = err.unused_opcode_exec && !err.opcode_flushed;
        err_vec[2] = err.supply_dip_reset;
        err_vec[1] = err.trap_lockout;
        err_vec[0] = ext_rst;
        err_reset = |err_vec;
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.core_reset = 1'b0;
        st_nxt.irq_valid = 1'b0;
        st_nxt.irq_num = 6'h00;
        st_nxt.vec_num = 6'h00;
        st_nxt.irq_level = 3'h0;
        st_nxt.raw = req;
        if (err_reset) begin
            st_nxt.state = IVMR_ST_RESET;
            st_nxt.pc = IVMR_RESET_PC;
            st_nxt.core_reset = 1'b1;
            st_nxt.cause = err_vec;
        end else begin
            unique case (st_r.state)
                IVMR_ST_RESET: begin
                    st_nxt.pc = IVMR_RESET_PC;
                    st_nxt.state = IVMR_ST_FETCH_JUMP;
                end
                IVMR_ST_FETCH_JUMP: begin
                    st_nxt.pc = IVMR_TARGET_ADDR;
                    st_nxt.state = IVMR_ST_FETCH_TARGET;
                end
                IVMR_ST_FETCH_TARGET: begin
                    st_nxt.pc = fetch_word;
                    st_nxt.state = IVMR_ST_RUN;
                end
                IVMR_ST_RUN: begin
                    st_nxt.irq_valid = best_hit;
                    st_nxt.irq_num = best_num;
                    st_nxt.vec_num = best_num + IVMR_VEC_OFFSET;
                    st_nxt.irq_level = best_lvl;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r.state <= IVMR_ST_RESET;
            st_r.pc <= IVMR_RESET_PC;
            st_r.core_reset <= 1'b1;
            st_r.cause <= 6'h00;
            st_r.irq_valid <= 1'b0;
            st_r.irq_num <= 6'h00;
            st_r.vec_num <= 6'h00;
            st_r.irq_level <= 3'h0;
            st_r.raw <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // level and raw vector are registered with the selection so all data outputs move together
    assign irq_valid = st_r.irq_valid;
    assign irq_num = st_r.irq_num;
    assign vec_num = st_r.vec_num;
    assign irq_level = st_r.irq_level;
    assign irq_raw = st_r.raw;
    assign core_reset = st_r.core_reset;
    assign reset_cause = st_r.cause;
    assign fetch_addr = st_r.pc;
    assign fetch_req = st_r.state == IVMR_ST_FETCH_JUMP || st_r.state == IVMR_ST_FETCH_TARGET;
    assign core_run = st_r.state == IVMR_ST_RUN;
endmodule

// ---- common/ivmr_pkg.sv ----
// constants, types and source map for the interrupt vector map and reset entry block
// How it works
// - vector number equals interrupt number plus eight.
// - equal-priority ties go to the lower interrupt number, 0 highest.
// - external pins zero to three map to numbers 0, 16, 23, 36.
// - capture one, compare one, timer one at 1-3; then 4-7.
// - serial port at 8, async receiver at 9, transmitter at 10.
// - converter done event sits at number 11.
// - nonvolatile write complete sits at number 12.
// - two-wire target 13, controller 14, pin change 15.
// - capture seven at 17, capture eight at 18.
// - period match 39, encoder 40, fault input A at 43.
// - reset skips the interrupt controller and forces the program counter to zero.
// - after reset fetch at zero: jump word, then target word, then run.
// - exactly five error conditions besides pin and power-on reset.
// - watchdog expiry resets the device.
// - uninitialised register used as pointer resets the device.
// - executing an unused opcode raises the illegal-instruction reset.
// - a flushed unused opcode raises nothing.
// - supply dip detection resets the device.
// - several traps at once reset the device.
package ivmr_pkg;
    localparam int IVMR_NUM_IRQ = 54;
    localparam int IVMR_NUM_W = 16;
    localparam logic [5:0] IVMR_VEC_OFFSET = 6'h08;
    localparam logic [23:0] IVMR_RESET_PC = 24'h000000;
    localparam logic [23:0] IVMR_TARGET_ADDR = 24'h000002;
    localparam int IVMR_NUM_ERR_SRC = 6;
    localparam logic [5:0] IVMR_IRQ_EXT0 = 6'h00;
    localparam logic [5:0] IVMR_IRQ_CAP1 = 6'h01;
    localparam logic [5:0] IVMR_IRQ_CMP1 = 6'h02;
    localparam logic [5:0] IVMR_IRQ_TMR1 = 6'h03;
    localparam logic [5:0] IVMR_IRQ_CAP2 = 6'h04;
    localparam logic [5:0] IVMR_IRQ_CMP2 = 6'h05;
    localparam logic [5:0] IVMR_IRQ_TMR2 = 6'h06;
    localparam logic [5:0] IVMR_IRQ_TMR3 = 6'h07;
    localparam logic [5:0] IVMR_IRQ_SPI = 6'h08;
    localparam logic [5:0] IVMR_IRQ_ARX = 6'h09;
    localparam logic [5:0] IVMR_IRQ_ATX = 6'h0A;
    localparam logic [5:0] IVMR_IRQ_ADC = 6'h0B;
    localparam logic [5:0] IVMR_IRQ_NVW = 6'h0C;
    localparam logic [5:0] IVMR_IRQ_TWT = 6'h0D;
    localparam logic [5:0] IVMR_IRQ_TWC = 6'h0E;
    localparam logic [5:0] IVMR_IRQ_PCHG = 6'h0F;
    localparam logic [5:0] IVMR_IRQ_EXT1 = 6'h10;
    localparam logic [5:0] IVMR_IRQ_CAP7 = 6'h11;
    localparam logic [5:0] IVMR_IRQ_CAP8 = 6'h12;
    localparam logic [5:0] IVMR_IRQ_EXT2 = 6'h17;
    localparam logic [5:0] IVMR_IRQ_EXT3 = 6'h24;
    localparam logic [5:0] IVMR_IRQ_PWMP = 6'h27;
    localparam logic [5:0] IVMR_IRQ_QENC = 6'h28;
    localparam logic [5:0] IVMR_IRQ_PWM_FAULT_INPUT_A = 6'h2B;

    // one request line per peripheral or pin
    typedef struct packed {
        logic ext_irq_zero;
        logic ext_irq_one;
        logic ext_irq_two;
        logic ext_irq_three;
        logic capture_ch_one;
        logic capture_ch_two;
        logic capture_ch_seven;
        logic capture_ch_eight;
        logic compare_ch_one;
        logic compare_ch_two;
        logic timer_one;
        logic timer_two;
        logic timer_three;
        logic spi_event;
        logic async_rx_event;
        logic async_tx_event;
        logic adc_done_event;
        logic nonvolatile_write_done;
        logic two_wire_target_event;
        logic two_wire_controller_event;
        logic pin_change_event;
        logic pwm_period_match;
        logic quadrature_encoder_event;
        logic pwm_fault_input_a;
    } ivmr_src_s;

    // error conditions that trap to the reset vector
    typedef struct packed {
        logic watchdog_expired;
        logic uninit_w_pointer;
        logic unused_opcode_exec;
        logic opcode_flushed;
        logic supply_dip_reset;
        logic trap_lockout;
    } ivmr_err_s;

    typedef enum logic [1:0] {
        IVMR_ST_RESET = 2'b00,
        IVMR_ST_FETCH_JUMP = 2'b01,
        IVMR_ST_FETCH_TARGET = 2'b10,
        IVMR_ST_RUN = 2'b11
    } ivmr_state_e;

    typedef struct packed {
        ivmr_state_e state;
        logic [23:0] pc;
        logic core_reset;
        logic [5:0] cause;
        logic irq_valid;
        logic [5:0] irq_num;
        logic [5:0] vec_num;
        logic [2:0] irq_level;
        logic [IVMR_NUM_IRQ-1:0] raw;
    } ivmr_state_s;
endpackage

// ---- tb/ivmr_top_assertions.sv ----
// port assertions for the vector map and reset entry block
module ivmr_top_checker
    import ivmr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ext_rst,
    input wire ivmr_err_s err,
    input wire logic [23:0] fetch_word,
    input wire logic irq_valid,
    input wire logic [5:0] irq_num,
    input wire logic [5:0] vec_num,
    input wire logic [IVMR_NUM_IRQ-1:0] irq_raw,
    input wire logic core_reset,
    input wire logic [5:0] reset_cause,
    input wire logic [23:0] fetch_addr,
    input wire logic fetch_req,
    input wire logic core_run
);
    timeunit 1ns;
    timeprecision 1ps;
    // numbers with a source behind them; all other bits are reserved slots
    localparam logic [53:0] USED_MASK = 54'h0990_0087_FFFF;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_vec_pair;
        irq_valid |-> vec_num == irq_num + 6'h08;
    endproperty
    a_vec_pair: assert property (p_vec_pair) else $error("vector number off");
    property p_reserved;
        (irq_raw & ~USED_MASK) == 54'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved request");
    property p_entry;
        $fell(sys_rst) |=> fetch_req && fetch_addr == 24'h000000
            ##1 fetch_req && fetch_addr == 24'h000002
            ##1 core_run && fetch_addr == $past(fetch_word);
    endproperty
    a_entry: assert property (p_entry) else $error("reset entry order");
    property p_ext;
        ext_rst |=> core_reset && reset_cause[0] && fetch_addr == 24'h000000 && !core_run;
    endproperty
    a_ext: assert property (p_ext) else $error("pin reset missed");
    property p_wdt;
        err.watchdog_expired |=> core_reset && reset_cause[5];
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog reset missed");
    property p_uninit;
        err.uninit_w_pointer |=> core_reset && reset_cause[4];
    endproperty
    a_uninit: assert property (p_uninit) else $error("pointer reset missed");
    property p_illegal;
        err.unused_opcode_exec && !err.opcode_flushed |=> core_reset && reset_cause[3];
    endproperty
    a_illegal: assert property (p_illegal) else $error("opcode reset missed");
    property p_flushed;
        err == 6'h0C && !ext_rst |=> !core_reset;
    endproperty
    a_flushed: assert property (p_flushed) else $error("flushed opcode reset");
    property p_dip_lock;
        err.supply_dip_reset || err.trap_lockout |=> core_reset && !fetch_req;
    endproperty
    a_dip_lock: assert property (p_dip_lock) else $error("dip or lockout");
    property p_gate;
        !core_run |=> !irq_valid;
    endproperty
    a_gate: assert property (p_gate) else $error("request outside run");
endmodule

bind ivmr_top ivmr_top_checker chk_u (.clk, .sys_rst, .ext_rst, .err, .fetch_word, .irq_valid,
    .irq_num, .vec_num, .irq_raw, .core_reset, .reset_cause, .fetch_addr, .fetch_req, .core_run);

// ---- tb/ivmr_core_model.sv ----
// core fetch side: program memory holding the jump word and its target
module ivmr_core_model #(
    parameter logic [23:0] JUMP_WORD = 24'h040000,
    parameter logic [23:0] START_ADDR = 24'h000140
)
(
    input wire logic clk,
    input wire logic fetch_req,
    input wire logic [23:0] fetch_addr,
    output logic [23:0] fetch_word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] junk_r = 24'hA5A5A5;
    // unrequested words churn so a stale value can never pass as good
    always_ff @(posedge clk) begin
        junk_r <= {junk_r[22:0], ~junk_r[23]};
    end
    // jump word at zero, target word after it
    assign fetch_word = !fetch_req ? junk_r :
        (fetch_addr == 24'h000000) ? JUMP_WORD :
        (fetch_addr == 24'h000002) ? START_ADDR : junk_r;
endmodule

// ---- tb/tb_irq_vector_map_and_reset_entry.sv ----
// self-checking bench for the vector map and reset entry block
module tb_irq_vector_map_and_reset_entry
    import ivmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [23:0] START_ADDR = 24'h000140;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ext_rst = 1'b0;
    ivmr_src_s src = '0;
    logic [IVMR_NUM_IRQ-1:0] irq_enable = '0;
    logic [IVMR_NUM_IRQ*3-1:0] irq_priority = '0;
    ivmr_err_s err = '0;
    logic [23:0] fetch_word, fetch_addr;
    logic irq_valid, core_reset, fetch_req, core_run;
    logic [2:0] irq_level;
    logic [IVMR_NUM_IRQ-1:0] irq_raw;
    logic [5:0] irq_num, vec_num, reset_cause;
    int n_mismatch = 0;
    int compares = 0;
    // number of each source, in field order of the request struct
    int src_num[24] = '{0, 16, 23, 36, 1, 4, 17, 18, 2, 5, 3, 6,
        7, 8, 9, 10, 11, 12, 13, 14, 15, 39, 40, 43};

    ivmr_top dut_u (.clk, .sys_rst, .ext_rst, .src, .irq_enable, .irq_priority, .err,
        .fetch_word, .irq_valid, .irq_num, .vec_num, .irq_level, .irq_raw, .core_reset,
        .reset_cause, .fetch_addr, .fetch_req, .core_run);
    ivmr_core_model #(.START_ADDR(START_ADDR)) mem_u (.clk, .fetch_req, .fetch_addr, .fetch_word);

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic close_out();
        if (n_mismatch == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [23:0] exp, logic [23:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic expect_irq(logic [5:0] n);
        tick();
        chk("irq_valid", 24'h000001, 24'(irq_valid));
        chk("irq_num", 24'(n), 24'(irq_num));
        chk("vec_num", 24'(n + 6'h08), 24'(vec_num));
    endtask

    // waits out the reset state, then walks jump fetch, target fetch and run
    task automatic check_entry();
        int k;
        k = 0;
        while (fetch_req !== 1'b1 && k < 8) begin
            tick();
            k++;
        end
        chk("entry_addr", 24'h000000, fetch_addr);
        tick();
        chk("target_addr", 24'h000002, fetch_addr);
        tick();
        chk("core_run", 24'h000001, 24'(core_run));
        chk("start_addr", START_ADDR, fetch_addr);
    endtask

    task automatic t_map(int lo, int hi);
        @(posedge clk);
        irq_enable <= '1;
        irq_priority <= {IVMR_NUM_IRQ{3'h1}};
        for (int i = lo; i < hi; i++) begin
            @(posedge clk);
            src <= ivmr_src_s'(24'h800000 >> i);
            expect_irq(6'(src_num[i]));
            chk("irq_level", 24'h000001, 24'(irq_level));
        end
    endtask

    // all sources at one level: lowest number wins until a level lifts one
    task automatic t_tie();
        @(posedge clk);
        src <= '1;
        expect_irq(6'h00);
        chk("irq_raw_lo", 24'h87FFFF, irq_raw[23:0]);
        chk("irq_raw_hi", 24'h099000, irq_raw[47:24]);
        @(posedge clk);
        irq_enable <= {14'h3FFF, 40'h0};
        expect_irq(6'h28);
        @(posedge clk);
        irq_priority[43*3+:3] <= 3'h7;
        expect_irq(6'h2B);
        chk("irq_level", 24'h000007, 24'(irq_level));
        // every source high, only reserved slots enabled: nothing may win
        @(posedge clk);
        irq_enable <= 54'h3F_F66F_FF78_0000;
        tick();
        chk("irq_reserved", 24'h000000, 24'(irq_valid));
        @(posedge clk);
        src <= '0;
        irq_enable <= '1;
        tick();
        chk("irq_idle", 24'h000000, 24'(irq_valid));
    endtask

    task automatic t_err(ivmr_err_s e, logic x, logic [5:0] cause);
        @(posedge clk);
        err <= e;
        ext_rst <= x;
        @(posedge clk);
        err <= '0;
        ext_rst <= 1'b0;
        #1;
        chk("core_reset", 24'h000001, 24'(core_reset));
        chk("reset_cause", 24'(cause), 24'(reset_cause));
        check_entry();
    endtask

    task automatic t_flush();
        @(posedge clk);
        err <= 6'h0C;
        @(posedge clk);
        err <= '0;
        #1;
        chk("flushed_reset", 24'h000000, 24'(core_reset));
        chk("flushed_run", 24'h000001, 24'(core_run));
    endtask

    // power-on reset in mid-run, with requests pending: async entry, then the fetch walk
    task automatic t_por();
        @(posedge clk);
        sys_rst <= 1'b1;
        #1;
        chk("por_reset", 24'h000001, 24'(core_reset));
        chk("por_pc", 24'h000000, fetch_addr);
        chk("por_run", 24'h000000, 24'(core_run));
        chk("por_irq", 24'h000000, 24'(irq_valid));
        chk("por_cause", 24'h000000, 24'(reset_cause));
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        check_entry();
    endtask

    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        check_entry();
        t_map(0, 4);
        t_map(4, 24);
        t_tie();
        // requests stay pending so entry after each reset runs with them present
        @(posedge clk);
        src <= '1;
        t_err(6'h20, 1'b0, 6'h20);
        t_err(6'h10, 1'b0, 6'h10);
        t_err(6'h08, 1'b0, 6'h08);
        t_err(6'h02, 1'b0, 6'h04);
        t_err(6'h01, 1'b0, 6'h02);
        t_err(6'h00, 1'b1, 6'h01);
        t_flush();
        t_por();
        close_out();
    end

    initial begin
        repeat (4000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
endmodule
